// >>> pkg/abx_regs.svh
// Constants for the AND, bit-clear and relative-branch executer
`ifndef ABX_REGS_SVH
`define ABX_REGS_SVH

// Opcode fields, matched against the top bits of the instruction word
`define ABX_OPC_AND_LIT 8'h0b
`define ABX_OPC_AND_FILE 6'h05
`define ABX_OPC_BR_CARRY 8'he2
`define ABX_OPC_BR_NEG 8'he6
`define ABX_OPC_BIT_CLR 4'h9

// Field positions within the instruction word
`define ABX_FLD_DEST 9
`define ABX_FLD_ACCESS 8
`define ABX_FLD_BIT_LO 9

// Addressing constants
`define ABX_INDEX_LIMIT 8'h5f
`define ABX_ACCESS_BANK 4'h0

// Phase numbers inside one instruction cycle
`define ABX_PH_DECODE 2'h0
`define ABX_PH_READ 2'h1
`define ABX_PH_PROC 2'h2
`define ABX_PH_WRITE 2'h3

// Reset values
`define ABX_RST_BYTE 8'h00
`define ABX_RST_ADDR 12'h000
`define ABX_RST_PC 21'h000000
`define ABX_RST_INSTR 16'h0000

`endif

// >>> pkg/abx_pkg.sv
// Types used by the executer; its address generator uses none of them
package abx_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ABX_ST_IDLE,
    ABX_ST_RUN,
    ABX_ST_NOP
  } abx_state_e;

  // Decoded operation kinds
  typedef enum logic [2:0] {
    ABX_OP_NONE,
    ABX_OP_AND_LIT,
    ABX_OP_AND_FILE,
    ABX_OP_BR_CARRY,
    ABX_OP_BR_NEG,
    ABX_OP_BIT_CLR
  } abx_op_e;

endpackage

// >>> rtl/abx_addr_gen.sv
// File operand address former: access bank, banked and indexed modes
`timescale 1ns/1ps
`default_nettype none
`include "abx_regs.svh"

module abx_addr_gen (
  input wire logic [7:0] file_field_i,
  input wire logic access_bit_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire logic [11:0] index_base_i,
  output logic [11:0] addr_o,
  output logic indexed_o
);

  assign indexed_o = !access_bit_i && ext_set_en_i && (file_field_i <= `ABX_INDEX_LIMIT);

  // Indexed offset wraps within the 12-bit data space
  always_comb
  begin
    if (indexed_o)
    begin
      addr_o = 12'(index_base_i + {4'h0, file_field_i});
    end
    else if (access_bit_i)
    begin
      addr_o = {bank_select_reg_i, file_field_i};
    end
    else
    begin
      addr_o = {`ABX_ACCESS_BANK, file_field_i};
    end
  end

endmodule
`default_nettype wire

// >>> rtl/abx_exec.sv
// Decode and four-phase execution of AND, bit-clear and relative branches
`timescale 1ns/1ps
`default_nettype none
`include "abx_regs.svh"

module abx_exec (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [20:0] pc_inc_i,
  input wire logic [7:0] acc_i,
  input wire logic carry_i,
  input wire logic negative_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic ext_set_en_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] mem_rdata_i,
  output logic instr_ready_o,
  output logic [11:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  output logic acc_we_o,
  output logic [7:0] acc_wdata_o,
  output logic flag_we_o,
  output logic flag_n_o,
  output logic flag_z_o,
  output logic pc_load_o,
  output logic [20:0] pc_target_o,
  output logic unknown_op_o,
  output logic instr_done_o
);

  // Opcode decoder, shared by the operation and the unknown-opcode logic
  function automatic abx_pkg::abx_op_e decode_op(input logic [15:0] w);
    return (w[15:8] == `ABX_OPC_AND_LIT) ? abx_pkg::ABX_OP_AND_LIT :
           (w[15:10] == `ABX_OPC_AND_FILE) ? abx_pkg::ABX_OP_AND_FILE :
           (w[15:8] == `ABX_OPC_BR_CARRY) ? abx_pkg::ABX_OP_BR_CARRY :
           (w[15:8] == `ABX_OPC_BR_NEG) ? abx_pkg::ABX_OP_BR_NEG :
           (w[15:12] == `ABX_OPC_BIT_CLR) ? abx_pkg::ABX_OP_BIT_CLR :
           abx_pkg::ABX_OP_NONE;
  endfunction

  abx_pkg::abx_state_e st_ff, nxt_st;
  abx_pkg::abx_op_e op_ff;
  logic [1:0] phase_ff, nxt_phase;
  logic [15:0] instr_ff;
  logic [20:0] pc_ff, pc_target_ff, branch_target;
  logic [11:0] mem_addr_ff, file_addr;
  logic [7:0] mem_wdata_ff, acc_wdata_ff, clr_mask, and_result, clr_result;
  logic ready_ff, done_ff, unknown_ff, mem_rd_ff, mem_we_ff, acc_we_ff;
  logic flag_we_ff, flag_n_ff, flag_z_ff, pc_load_ff;
  logic branch_cond, run_decode, run_proc, accept;

  // Phase strobes; nothing happens in the no-op cycle
  assign run_decode = (st_ff == abx_pkg::ABX_ST_RUN) && (phase_ff == `ABX_PH_DECODE);
  assign run_proc = (st_ff == abx_pkg::ABX_ST_RUN) && (phase_ff == `ABX_PH_PROC);
  assign accept = (st_ff == abx_pkg::ABX_ST_IDLE) && instr_valid_i;

  // File operand address from the latched word
  abx_addr_gen u_addr_gen (
    .file_field_i(instr_ff[7:0]),
    .access_bit_i(instr_ff[`ABX_FLD_ACCESS]),
    .bank_select_reg_i(bank_select_reg_i),
    .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i),
    .addr_o(file_addr),
    .indexed_o()
  );

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_mask
      assign clr_mask[gi] = (instr_ff[`ABX_FLD_BIT_LO+2:`ABX_FLD_BIT_LO] != 3'(gi));
    end
  endgenerate

  assign and_result = (op_ff == abx_pkg::ABX_OP_AND_LIT) ? (acc_i & instr_ff[7:0])
                                                         : (acc_i & mem_rdata_i);

  assign clr_result = mem_rdata_i & clr_mask;

  assign branch_target = 21'(pc_ff + {{12{instr_ff[7]}}, instr_ff[7:0], 1'b0});

  assign branch_cond = ((op_ff == abx_pkg::ABX_OP_BR_CARRY) && carry_i) ||
                       ((op_ff == abx_pkg::ABX_OP_BR_NEG) && negative_i);

  // Next state and phase of the sequencer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_phase = phase_ff;
    case (st_ff)
      abx_pkg::ABX_ST_IDLE:
      begin
        if (instr_valid_i)
        begin
          nxt_st = abx_pkg::ABX_ST_RUN;
          nxt_phase = `ABX_PH_DECODE;
        end
      end
      abx_pkg::ABX_ST_RUN:
      begin
        nxt_phase = 2'(phase_ff + 2'h1);
        if (phase_ff == `ABX_PH_WRITE)
        begin
          nxt_st = pc_load_ff ? abx_pkg::ABX_ST_NOP : abx_pkg::ABX_ST_IDLE; // Load marks taken
        end
      end
      abx_pkg::ABX_ST_NOP:
      begin
        nxt_phase = 2'(phase_ff + 2'h1);
        if (phase_ff == `ABX_PH_WRITE)
        begin
          nxt_st = abx_pkg::ABX_ST_IDLE;
        end
      end
      default:
      begin
        nxt_st = abx_pkg::ABX_ST_IDLE;
        nxt_phase = `ABX_PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= abx_pkg::ABX_ST_IDLE;
      phase_ff <= `ABX_PH_DECODE;
    end
    else
    begin
      st_ff <= nxt_st;
      phase_ff <= nxt_phase;
    end
  end

  // Ready only while idle, so a word is never taken mid-instruction
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      ready_ff <= (nxt_st == abx_pkg::ABX_ST_IDLE) && !accept;
      done_ff <= (st_ff != abx_pkg::ABX_ST_IDLE) && (nxt_st == abx_pkg::ABX_ST_IDLE);
    end
  end

  // Instruction word and incremented counter latched on acceptance
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      instr_ff <= `ABX_RST_INSTR;
      pc_ff <= `ABX_RST_PC;
    end
    else if (accept)
    begin
      instr_ff <= instr_i;
      pc_ff <= pc_inc_i;
    end
  end

  // Decode phase: classify the word; unknown words flag once and run as a no-op
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      op_ff <= abx_pkg::ABX_OP_NONE;
      unknown_ff <= 1'b0;
    end
    else
    begin
      unknown_ff <= run_decode && (decode_op(instr_ff) == abx_pkg::ABX_OP_NONE);
      if (run_decode)
      begin
        op_ff <= decode_op(instr_ff);
      end
    end
  end

  // Operand read: file address and read strobe stand during the read phase
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      mem_addr_ff <= `ABX_RST_ADDR;
      mem_rd_ff <= 1'b0;
    end
    else
    begin
      mem_rd_ff <= 1'b0;
      if (run_decode)
      begin
        mem_addr_ff <= file_addr;
        mem_rd_ff <= (decode_op(instr_ff) == abx_pkg::ABX_OP_AND_FILE) ||
                     (decode_op(instr_ff) == abx_pkg::ABX_OP_BIT_CLR);
      end
    end
  end

  // Accumulator write in the write phase
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      acc_we_ff <= 1'b0;
      acc_wdata_ff <= `ABX_RST_BYTE;
    end
    else
    begin
      acc_we_ff <= 1'b0;
      if (run_proc)
      begin
        acc_wdata_ff <= and_result;
        acc_we_ff <= (op_ff == abx_pkg::ABX_OP_AND_LIT) ||
                     ((op_ff == abx_pkg::ABX_OP_AND_FILE) && !instr_ff[`ABX_FLD_DEST]);
      end
    end
  end

  // File register write in the write phase
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      mem_we_ff <= 1'b0;
      mem_wdata_ff <= `ABX_RST_BYTE;
    end
    else
    begin
      mem_we_ff <= 1'b0;
      if (run_proc)
      begin
        if ((op_ff == abx_pkg::ABX_OP_AND_FILE) && instr_ff[`ABX_FLD_DEST])
        begin
          mem_we_ff <= 1'b1;
          mem_wdata_ff <= and_result;
        end
        else if (op_ff == abx_pkg::ABX_OP_BIT_CLR)
        begin
          mem_we_ff <= 1'b1;
          mem_wdata_ff <= clr_result;
        end
      end
    end
  end

  // Status flags; bit clear and branches leave them alone
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      flag_we_ff <= 1'b0;
      flag_n_ff <= 1'b0;
      flag_z_ff <= 1'b0;
    end
    else
    begin
      flag_we_ff <= 1'b0;
      if (run_proc && ((op_ff == abx_pkg::ABX_OP_AND_LIT) ||
                       (op_ff == abx_pkg::ABX_OP_AND_FILE)))
      begin
        flag_we_ff <= 1'b1;
        flag_n_ff <= and_result[7];
        flag_z_ff <= (and_result == 8'h00);
      end
    end
  end

  // Counter load in the write phase of a taken branch
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pc_load_ff <= 1'b0;
      pc_target_ff <= `ABX_RST_PC;
    end
    else
    begin
      pc_load_ff <= 1'b0;
      if (run_proc && branch_cond)
      begin
        pc_load_ff <= 1'b1;
        pc_target_ff <= branch_target;
      end
    end
  end

  // Outputs straight from flip-flops
  assign instr_ready_o = ready_ff;
  assign mem_addr_o = mem_addr_ff;
  assign mem_rd_o = mem_rd_ff;
  assign mem_we_o = mem_we_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign acc_we_o = acc_we_ff;
  assign acc_wdata_o = acc_wdata_ff;
  assign flag_we_o = flag_we_ff;
  assign flag_n_o = flag_n_ff;
  assign flag_z_o = flag_z_ff;
  assign pc_load_o = pc_load_ff;
  assign pc_target_o = pc_target_ff;
  assign unknown_op_o = unknown_ff;
  assign instr_done_o = done_ff;

endmodule
`default_nettype wire

// >>> bench/abx_exec_assertions.sv
// Port checker for the AND, bit-clear and branch executer
`timescale 1ns/1ps
`default_nettype none
module abx_exec_assertions (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic instr_ready_o,
  input wire logic mem_rd_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic acc_we_o,
  input wire logic [7:0] acc_wdata_o,
  input wire logic flag_we_o,
  input wire logic flag_n_o,
  input wire logic flag_z_o,
  input wire logic pc_load_o,
  input wire logic instr_done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Result as written, whichever destination
  wire logic [7:0] res = acc_we_o ? acc_wdata_o : mem_wdata_o;
  // Any data or flag write of the write phase
  wire logic any_wr = acc_we_o || mem_we_o || flag_we_o;
  // Second cycle of a taken branch does nothing
  sequence nop_s;
    !mem_we_o && !acc_we_o && !flag_we_o && !mem_rd_o && !instr_done_o;
  endsequence
  // Flags follow the written result
  property flag_calc_p;
    flag_we_o |-> flag_z_o == (res == 8'h00) && flag_n_o == res[7];
  endproperty
  // Bit clear only lowers bits of the read byte, at most one
  property clr_one_p;
    mem_we_o && !flag_we_o |-> (mem_wdata_o & ~$past(mem_rdata_i)) == 8'h00 &&
      $countones(mem_wdata_o ^ $past(mem_rdata_i)) <= 1;
  endproperty
  // File AND written back to memory
  property and_file_p;
    mem_we_o && flag_we_o |-> mem_wdata_o == ($past(mem_rdata_i) & $past(acc_i));
  endproperty
  rd_to_done_a: assert property (mem_rd_o |-> !instr_ready_o ##3 instr_done_o)
    else $error("done not three cycles after read");
  wr_to_done_a: assert property (any_wr |=> instr_done_o && instr_ready_o)
    else $error("done not right after write phase");
  taken_nop_a: assert property (pc_load_o |=> nop_s [*4] ##1 instr_done_o)
    else $error("taken branch second cycle not idle");
  dest_excl_a: assert property (acc_we_o |-> !mem_we_o)
    else $error("both destinations written");
  flag_calc_a: assert property (flag_calc_p)
    else $error("flags do not match result");
  br_quiet_a: assert property (pc_load_o |-> !flag_we_o && !mem_we_o && !acc_we_o)
    else $error("branch wrote data or flags");
  clr_one_a: assert property (clr_one_p)
    else $error("bit clear changed more than one bit");
  and_file_a: assert property (and_file_p)
    else $error("file AND result wrong");
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the AND, bit-clear and branch executer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [20:0] pc_inc_i = 21'h000000;
  logic [7:0] acc_i = 8'h00;
  logic carry_i = 1'b0;
  logic negative_i = 1'b0;
  logic [3:0] bank_select_reg_i = 4'h0;
  logic ext_set_en_i = 1'b0;
  logic [11:0] index_base_i = 12'h000;
  logic [7:0] mem_rdata_i = 8'h00;
  logic instr_ready_o, mem_rd_o, mem_we_o, acc_we_o, flag_we_o, flag_n_o, flag_z_o;
  logic pc_load_o, unknown_op_o, instr_done_o;
  logic [11:0] mem_addr_o, g_a;
  logic [7:0] mem_wdata_o, acc_wdata_o, g_v, g_d;
  logic [20:0] pc_target_o, g_t;
  int g_lat, err_total = 0, tests_run = 0, cyc = 0;
  abx_exec dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pc_inc_i(pc_inc_i), .acc_i(acc_i), .carry_i(carry_i),
    .negative_i(negative_i), .bank_select_reg_i(bank_select_reg_i), .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i), .instr_ready_o(instr_ready_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .acc_we_o(acc_we_o), .acc_wdata_o(acc_wdata_o), .flag_we_o(flag_we_o), .flag_n_o(flag_n_o),
    .flag_z_o(flag_z_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
    .unknown_op_o(unknown_op_o), .instr_done_o(instr_done_o));
  // 50 MHz clock
  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_sim;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Cut a hang short; the whole run needs well under this
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    begin
      tests_run++;
      if (g !== e)
      begin
        err_total++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Offer one word, then log strobes {rd,we,acc,flag,n,z,pc,unk} until done
  task automatic run(input logic [15:0] w, input logic [7:0] a, input logic [1:0] cn,
    input logic [7:0] rd);
    int k;
    begin
      k = 0;
      while (instr_ready_o !== 1'b1 && k < 20)
      begin
        @(negedge clk_sys_i);
        k++;
      end
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      acc_i <= a;
      {carry_i, negative_i} <= cn;
      mem_rdata_i <= rd;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      g_v = 8'h00;
      g_d = 8'h00;
      g_a = 12'h000;
      g_t = 21'h000000;
      for (k = 0; k < 12; k++)
      begin
        @(negedge clk_sys_i);
        g_v = g_v | {mem_rd_o, mem_we_o, acc_we_o, flag_we_o, flag_n_o & flag_we_o,
          flag_z_o & flag_we_o, pc_load_o, unknown_op_o};
        if (mem_rd_o === 1'b1) g_a = mem_addr_o;
        if (mem_we_o === 1'b1) g_d = mem_wdata_o;
        if (acc_we_o === 1'b1) g_d = acc_wdata_o;
        if (pc_load_o === 1'b1) g_t = pc_target_o;
        if (instr_done_o === 1'b1) break;
      end
      g_lat = k;
    end
  endtask
  task automatic want(input int lat, input logic [7:0] v, input logic [7:0] d,
    input logic [11:0] a, input logic [20:0] t);
    begin
      chk("cycles to done", 21'(lat), 21'(g_lat));
      chk("strobes", {13'h0, v}, {13'h0, g_v});
      chk("data", {13'h0, d}, {13'h0, g_d});
      chk("address", {9'h0, a}, {9'h0, g_a});
      chk("target", t, g_t);
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    pc_inc_i <= 21'h001000;
    index_base_i <= 12'h100;
    bank_select_reg_i <= 4'h3;
    repeat (2) @(posedge clk_sys_i);
    chk("ready after reset", 21'h1, {20'h0, instr_ready_o});
    run(16'h0b5f, 8'ha3, 2'b00, 8'h00);
    want(4, 8'h30, 8'h03, 12'h000, 21'h0);
    run(16'h0b80, 8'hf0, 2'b00, 8'h00);
    want(4, 8'h38, 8'h80, 12'h000, 21'h0);
    run(16'h0b0f, 8'hf0, 2'b11, 8'h00);
    want(4, 8'h34, 8'h00, 12'h000, 21'h0);
    run(16'h1412, 8'h17, 2'b00, 8'hc2);
    want(4, 8'hb0, 8'h02, 12'h012, 21'h0);
    run(16'h1712, 8'hff, 2'b00, 8'h81);
    want(4, 8'hd8, 8'h81, 12'h312, 21'h0);
    @(posedge clk_sys_i);
    ext_set_en_i <= 1'b1;
    run(16'h145f, 8'hff, 2'b00, 8'h01);
    want(4, 8'hb0, 8'h01, 12'h15f, 21'h0);
    run(16'h1460, 8'hff, 2'b00, 8'h01);
    want(4, 8'hb0, 8'h01, 12'h060, 21'h0);
    run(16'h155f, 8'hff, 2'b00, 8'h01);
    want(4, 8'hb0, 8'h01, 12'h35f, 21'h0);
    @(posedge clk_sys_i);
    ext_set_en_i <= 1'b0;
    for (int b = 0; b < 8; b++)
    begin
      run({4'h9, b[2:0], 1'b1, 8'h34}, 8'h00, 2'b11, 8'hff);
      want(4, 8'hc0, ~(8'h01 << b), 12'h334, 21'h0);
    end
    run(16'h9e34, 8'h00, 2'b00, 8'hc7);
    want(4, 8'hc0, 8'h47, 12'h034, 21'h0);
    run(16'he205, 8'h00, 2'b10, 8'h00);
    want(8, 8'h02, 8'h00, 12'h000, 21'h00100a);
    run(16'he280, 8'h00, 2'b10, 8'h00);
    want(8, 8'h02, 8'h00, 12'h000, 21'h000f00);
    run(16'he205, 8'h00, 2'b01, 8'h00);
    want(4, 8'h00, 8'h00, 12'h000, 21'h0);
    run(16'he6ff, 8'h00, 2'b01, 8'h00);
    want(8, 8'h02, 8'h00, 12'h000, 21'h000ffe);
    run(16'he67f, 8'h00, 2'b10, 8'h00);
    want(4, 8'h00, 8'h00, 12'h000, 21'h0);
    run(16'hffff, 8'h00, 2'b00, 8'h00);
    want(4, 8'h01, 8'h00, 12'h000, 21'h0);
    end_sim();
  end
endmodule
bind abx_exec abx_exec_assertions chk_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .acc_i(acc_i), .mem_rdata_i(mem_rdata_i), .instr_ready_o(instr_ready_o), .mem_rd_o(mem_rd_o),
  .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .acc_we_o(acc_we_o), .acc_wdata_o(acc_wdata_o),
  .flag_we_o(flag_we_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .pc_load_o(pc_load_o),
  .instr_done_o(instr_done_o));
`default_nettype wire
